// ===== hdl/srcc_pkg.sv
package srcc_pkg;

  // ==========================================================================
  // Register indices. Byte address is four times the index.
  localparam logic [13:0] IDX_ASYNC_ENABLE  = 14'h0ee0;
  localparam logic [13:0] IDX_ASYNC_STATUS  = 14'h0ee1;
  localparam logic [13:0] IDX_ASYNC_RATE1   = 14'h0ee2;
  localparam logic [13:0] IDX_ASYNC_RATE2   = 14'h0ee3;
  localparam logic [13:0] IDX_ISO1_HIGH     = 14'h0ef0;
  localparam logic [13:0] IDX_ISO1_LOW      = 14'h0ef1;
  localparam logic [13:0] IDX_ISO1_ENABLE   = 14'h0ef2;
  localparam logic [13:0] IDX_ISO2_HIGH     = 14'h0ef3;
  localparam logic [13:0] IDX_ISO2_LOW      = 14'h0ef4;
  localparam logic [13:0] IDX_ISO2_ENABLE   = 14'h0ef5;
  localparam logic [13:0] IDX_ISO_STATUS    = 14'h0ef6;

  // ==========================================================================
  // Field positions and reset values.
  localparam int RATE_LSB = 11;
  localparam int RATE_MSB = 15;
  localparam int ISO_INT1_BIT = 15;
  localparam int ISO_INT2_BIT = 14;
  localparam int ISO_DEC1_BIT = 9;
  localparam int ISO_DEC2_BIT = 8;
  localparam logic [4:0] RST_ASYNC_RATE1 = 5'h00;
  localparam logic [4:0] RST_ASYNC_RATE2 = 5'h08;
  localparam logic [4:0] RST_ISO_RATE    = 5'h00;
  localparam int NUM_ASYNC_PATHS = 4;
  localparam int NUM_ISO_PATHS   = 4;
  localparam int NUM_ISO         = 2;

  // ==========================================================================
  // Shared rate code set.
  localparam logic [4:0] RATE_SYS_1   = 5'h00;
  localparam logic [4:0] RATE_SYS_2   = 5'h01;
  localparam logic [4:0] RATE_SYS_3   = 5'h02;
  localparam logic [4:0] RATE_ASYNC_A = 5'h08;
  localparam logic [4:0] RATE_ASYNC_B = 5'h09;

  function automatic logic srcc_rate_valid(input logic [4:0] code);
    return (code == RATE_SYS_1) || (code == RATE_SYS_2)
        || (code == RATE_SYS_3) || (code == RATE_ASYNC_A)
        || (code == RATE_ASYNC_B);
  endfunction

  function automatic logic srcc_rate_async(input logic [4:0] code);
    return (code == RATE_ASYNC_A) || (code == RATE_ASYNC_B);
  endfunction

endpackage

// ===== hdl/srcc_path_if.sv
`timescale 1ns/1ps
`default_nettype none
interface srcc_path_if;
  logic req;
  logic rateOk;
  logic clkOk;
  logic active;
  modport gate (input req, input rateOk, input clkOk, output active);
  modport ctrl (output req, output rateOk, output clkOk, input active);
endinterface
`default_nettype wire

// ===== hdl/srcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module srcc_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end
    else
    begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // A bit is accepted only once the second and third stages agree.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      q <= '0;
    else
      for (int i = 0; i < WIDTH; i++)
        if (ff2[i] == ff3[i])
          q[i] <= ff3[i];
  end
endmodule
`default_nettype wire

// ===== hdl/srcc_path_gate.sv
`timescale 1ns/1ps
`default_nettype none
module srcc_path_gate
(
  input  wire logic clk,
  input  wire logic rstN,
  srcc_path_if.gate pathIf
);
  // A path only starts when its rates are legal and its clock is adequate.
  // Once running, a later clock shortfall does not stop it.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      pathIf.active <= 1'b0;
    else if (!pathIf.req)
      pathIf.active <= 1'b0;
    else if (!pathIf.active && pathIf.rateOk && pathIf.clkOk)
      pathIf.active <= 1'b1;
  end
endmodule
`default_nettype wire

// ===== hdl/srcc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Async enable bits 3,2,1,0 select paths.
// - Read-only status shows four actual path enables.
// - Rate one field bits 15:11, shared codes.
// - Rate two field same codes, resets 0x08.
// - Two isochronous converters, four paths each.
// - Each interp/decim path has own enable bit.
// - Underclocked clock refuses new enables, running continue.
// - Iso high field bits 15:11, reset 0x00.
// - Iso enable bits 15,14,9 for paths.
// - Status after refusal shows actually enabled paths.
// - Async path lock state offered as event.
// - Iso enable bit 8 is decimation two.
module srcc_ctrl
  import srcc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wbCycI,
  input  wire logic        wbStbI,
  input  wire logic        wbWeI,
  input  wire logic [15:0] wbAdrI,
  input  wire logic [3:0]  wbSelI,
  input  wire logic [31:0] wbDatI,
  output var  logic [31:0] wbDatO,
  output var  logic        wbAckO,
  input  wire logic        sysClkAdequate,
  input  wire logic        asyncClkAdequate,
  input  wire logic [3:0]  asyncLockIn,
  output var  logic [3:0]  asyncPathRun,
  output var  logic [7:0]  isoPathRun,
  output var  logic [3:0]  asyncLockSts,
  output var  logic        asyncLockEvt
);

  // ==========================================================================
  // Reset release
  logic rstMeta;
  logic rstN;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] clkOkSync;
  logic [3:0] lockSync;

  srcc_sync #(.WIDTH(2)) uClkSync
  (
    .clk  (clk_sys),
    .rstN (rstN),
    .d    ({asyncClkAdequate, sysClkAdequate}),
    .q    (clkOkSync)
  );

  srcc_sync #(.WIDTH(4)) uLockSync
  (
    .clk  (clk_sys),
    .rstN (rstN),
    .d    (asyncLockIn),
    .q    (lockSync)
  );

  logic sysOk;
  logic asyncOk;
  assign sysOk   = clkOkSync[0];
  assign asyncOk = clkOkSync[1];

  // ==========================================================================
  // Wishbone decode
  logic        busReq;
  logic        busWr;
  logic [13:0] busIdx;
  logic [15:0] wrMask;
  logic [15:0] wrData;

  assign busReq = wbCycI && wbStbI && !wbAckO;
  assign busWr  = busReq && wbWeI;
  assign busIdx = wbAdrI[15:2];
  assign wrMask = {{8{wbSelI[1]}}, {8{wbSelI[0]}}};
  assign wrData = wbDatI[15:0];

  function automatic logic [15:0] mergeWr(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [15:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction

  // ==========================================================================
  // Control registers
  logic [3:0]  asyncEnR;
  logic [4:0]  asyncRate1R;
  logic [4:0]  asyncRate2R;
  logic [4:0]  isoHighR [NUM_ISO];
  logic [4:0]  isoLowR  [NUM_ISO];
  logic [3:0]  isoEnR   [NUM_ISO];
  logic [15:0] asyncEnWord;
  logic [15:0] asyncEnNxt;
  logic [15:0] rate1Nxt;
  logic [15:0] rate2Nxt;

  assign asyncEnWord = {12'h000, asyncEnR};
  assign asyncEnNxt  = mergeWr(asyncEnWord, wrData, wrMask);
  assign rate1Nxt    = mergeWr({asyncRate1R, 11'h000}, wrData, wrMask);
  assign rate2Nxt    = mergeWr({asyncRate2R, 11'h000}, wrData, wrMask);

  // Enable bit per path, bit 3 the reverse left path.
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      asyncEnR <= 4'h0;
    else if (busWr && busIdx == IDX_ASYNC_ENABLE)
      asyncEnR <= asyncEnNxt[3:0];
  end

  // Rate fields sit in the top five bits, so only the high byte select counts.
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      asyncRate1R <= RST_ASYNC_RATE1;
      asyncRate2R <= RST_ASYNC_RATE2;
    end
    else if (busWr && busIdx == IDX_ASYNC_RATE1)
      asyncRate1R <= rate1Nxt[RATE_MSB:RATE_LSB];
    else if (busWr && busIdx == IDX_ASYNC_RATE2)
      asyncRate2R <= rate2Nxt[RATE_MSB:RATE_LSB];
  end

  // Two isochronous converters with the same layout, three words apart.
  genvar g;
  generate
    for (g = 0; g < NUM_ISO; g++)
    begin : gIsoRegs
      localparam logic [13:0] BASE = IDX_ISO1_HIGH + 14'(3 * g);
      logic [15:0] enWord;
      logic [15:0] enNxt;

      logic [15:0] highNxt;
      logic [15:0] lowNxt;

      assign enWord  = {isoEnR[g][3:2], 4'h0, isoEnR[g][1:0], 8'h00};
      assign enNxt   = mergeWr(enWord, wrData, wrMask);
      assign highNxt = mergeWr({isoHighR[g], 11'h000}, wrData, wrMask);
      assign lowNxt  = mergeWr({isoLowR[g], 11'h000}, wrData, wrMask);

      always_ff @(posedge clk_sys or negedge rstN)
      begin
        if (!rstN)
        begin
          isoHighR[g] <= RST_ISO_RATE;
          isoLowR[g]  <= RST_ISO_RATE;
          isoEnR[g]   <= 4'h0;
        end
        else if (busWr && busIdx == BASE)
          isoHighR[g] <= highNxt[RATE_MSB:RATE_LSB];
        else if (busWr && busIdx == BASE + 14'h0001)
          isoLowR[g] <= lowNxt[RATE_MSB:RATE_LSB];
        else if (busWr && busIdx == BASE + 14'h0002)
          // Order inside isoEnR: int1, int2, dec1, dec2 from the top.
          isoEnR[g] <= {enNxt[ISO_INT1_BIT], enNxt[ISO_INT2_BIT],
                        enNxt[ISO_DEC1_BIT],
                        enNxt[ISO_DEC2_BIT]};
      end
    end
  endgenerate

  // ==========================================================================
  // Path gating
  logic asyncRatesOk;
  logic asyncClkOk;
  logic isoRatesOk [NUM_ISO];
  logic isoClkOk   [NUM_ISO];

  // Reserved codes make the whole converter unstartable.
  assign asyncRatesOk = srcc_rate_valid(asyncRate1R)
                     && srcc_rate_valid(asyncRate2R);
  assign asyncClkOk =
      (srcc_rate_async(asyncRate1R) ? asyncOk : sysOk)
   && (srcc_rate_async(asyncRate2R) ? asyncOk : sysOk);

  generate
    for (g = 0; g < NUM_ISO; g++)
    begin : gIsoChk
      // A mixed-domain pair cannot be clocked, so it is treated as invalid.
      assign isoRatesOk[g] = srcc_rate_valid(isoHighR[g])
                          && srcc_rate_valid(isoLowR[g])
                          && (srcc_rate_async(isoHighR[g])
                              == srcc_rate_async(isoLowR[g]));
      assign isoClkOk[g] = srcc_rate_async(isoHighR[g]) ? asyncOk
                                                        : sysOk;
    end
  endgenerate

  srcc_path_if asyncIf [NUM_ASYNC_PATHS] ();
  srcc_path_if isoIf   [NUM_ISO * NUM_ISO_PATHS] ();

  generate
    for (g = 0; g < NUM_ASYNC_PATHS; g++)
    begin : gAsyncPath
      assign asyncIf[g].req    = asyncEnR[g];
      assign asyncIf[g].rateOk = asyncRatesOk;
      assign asyncIf[g].clkOk  = asyncClkOk;

      srcc_path_gate uGate
      (
        .clk    (clk_sys),
        .rstN   (rstN),
        .pathIf (asyncIf[g])
      );
    end

    for (g = 0; g < NUM_ISO * NUM_ISO_PATHS; g++)
    begin : gIsoPath
      localparam int CONV = g / NUM_ISO_PATHS;
      localparam int PATH = g % NUM_ISO_PATHS;

      assign isoIf[g].req    = isoEnR[CONV][PATH];
      assign isoIf[g].rateOk = isoRatesOk[CONV];
      assign isoIf[g].clkOk  = isoClkOk[CONV];

      srcc_path_gate uGate
      (
        .clk    (clk_sys),
        .rstN   (rstN),
        .pathIf (isoIf[g])
      );
    end
  endgenerate

  logic [3:0] asyncActive;
  logic [7:0] isoActive;

  generate
    for (g = 0; g < NUM_ASYNC_PATHS; g++)
    begin : gAsyncAct
      assign asyncActive[g] = asyncIf[g].active;
    end
    for (g = 0; g < NUM_ISO * NUM_ISO_PATHS; g++)
    begin : gIsoAct
      assign isoActive[g] = isoIf[g].active;
    end
  endgenerate

  // Run outputs mirror the gate flip-flops one cycle later.
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      asyncPathRun <= 4'h0;
      isoPathRun   <= 8'h00;
    end
    else
    begin
      asyncPathRun <= asyncActive;
      isoPathRun   <= isoActive;
    end
  end

  // ==========================================================================
  // Lock state
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      asyncLockSts <= 4'h0;
      asyncLockEvt <= 1'b0;
    end
    else
    begin
      asyncLockSts <= lockSync;
      asyncLockEvt <= (lockSync != asyncLockSts);
    end
  end

  // ==========================================================================
  // Read mux and acknowledge
  logic [15:0] rdWord;

  always_comb
  begin
    rdWord = 16'h0000;
    unique case (busIdx)
      IDX_ASYNC_ENABLE: rdWord = asyncEnWord;
      IDX_ASYNC_STATUS: rdWord = {12'h000, asyncActive};
      IDX_ASYNC_RATE1:  rdWord = {asyncRate1R, 11'h000};
      IDX_ASYNC_RATE2:  rdWord = {asyncRate2R, 11'h000};
      IDX_ISO1_HIGH:    rdWord = {isoHighR[0], 11'h000};
      IDX_ISO1_LOW:     rdWord = {isoLowR[0], 11'h000};
      IDX_ISO1_ENABLE:  rdWord = gIsoRegs[0].enWord;
      IDX_ISO2_HIGH:    rdWord = {isoHighR[1], 11'h000};
      IDX_ISO2_LOW:     rdWord = {isoLowR[1], 11'h000};
      IDX_ISO2_ENABLE:  rdWord = gIsoRegs[1].enWord;
      IDX_ISO_STATUS:   rdWord = {8'h00, isoActive};
      default:          rdWord = 16'h0000;
    endcase
  end

  // Unmapped addresses are acknowledged with zero data so a stray access
  // never hangs the bus.
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      wbAckO <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end
    else
    begin
      wbAckO <= busReq;
      if (busReq && !wbWeI)
        wbDatO <= {16'h0000, rdWord};
    end
  end

endmodule
`default_nettype wire

// ===== dv/srcc_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Mixing core stand-in: clock adequacy and lock reports with a lag.
module srcc_partner
#(
  parameter int LAG = 3
)
(
  input  wire logic       clk_sys,
  input  wire logic       sysOkCmd,
  input  wire logic       asyncOkCmd,
  input  wire logic [3:0] lockCmd,
  output var  logic       sysClkAdequate,
  output var  logic       asyncClkAdequate,
  output var  logic [3:0] asyncLockIn
);
  logic [5:0] lag_r [LAG] = '{default: 6'h00};
  // Lock and adequacy never follow a change at once, as on real silicon.
  always @(posedge clk_sys)
  begin
    lag_r[0] <= {sysOkCmd, asyncOkCmd, lockCmd};
    for (int i = 1; i < LAG; i++)
      lag_r[i] <= lag_r[i-1];
  end
  assign {sysClkAdequate, asyncClkAdequate, asyncLockIn} = lag_r[LAG-1];
endmodule
`default_nettype wire

// ===== dv/srcc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module srcc_ctrl_monitor
  import srcc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        wbCycI,
  input wire logic        wbStbI,
  input wire logic        wbWeI,
  input wire logic [15:0] wbAdrI,
  input wire logic [3:0]  wbSelI,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic        wbAckO,
  input wire logic        sysClkAdequate,
  input wire logic        asyncClkAdequate,
  input wire logic [3:0]  asyncLockIn,
  input wire logic [3:0]  asyncPathRun,
  input wire logic [7:0]  isoPathRun,
  input wire logic [3:0]  asyncLockSts,
  input wire logic        asyncLockEvt
);
  // ==========================================================================
  // Helper terms.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic       take;
  logic       enWr;
  logic       isoWr;
  logic [3:0] offMask_r;
  logic [3:0] okAge_r;
  assign take  = wbCycI && wbStbI && !wbAckO;
  assign enWr  = take && wbWeI && wbAdrI[15:2] == IDX_ASYNC_ENABLE;
  assign isoWr = take && wbWeI && (wbAdrI[15:2] == IDX_ISO1_ENABLE
                 || wbAdrI[15:2] == IDX_ISO2_ENABLE);
  // The mask is kept because the master moves its data lines on.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      offMask_r <= 4'h0;
    else if (enWr && wbSelI[0])
      offMask_r <= ~wbDatI[3:0];
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      okAge_r <= 4'h0;
    else if (sysClkAdequate || asyncClkAdequate)
      okAge_r <= 4'h0;
    else if (okAge_r != 4'hf)
      okAge_r <= okAge_r + 4'h1;
  end
  // ==========================================================================
  // Properties.
  sequence sTake;
    take;
  endsequence
  sequence sAckPulse;
    wbAckO ##1 !wbAckO;
  endsequence
  ack_pulse_a: assert property (sTake |=> sAckPulse)
    else $error("ack not a single cycle answer");
  upper_zero_a: assert property (wbAckO |-> wbDatO[31:16] == 16'h0)
    else $error("read data upper half not zero");
  unmapped_read_a: assert property
    (take && !wbWeI && wbAdrI[15:2] > IDX_ISO_STATUS |=> wbDatO == 32'h0)
    else $error("unmapped read not zero");
  run_stop_a: assert property
    (enWr && wbSelI[0] |-> ##3 (asyncPathRun & offMask_r) == 4'h0)
    else $error("cleared path still runs");
  run_hold_a: assert property
    (|($past(asyncPathRun) & ~asyncPathRun)
     |-> $past(enWr, 2) || $past(enWr, 3) || $past(enWr, 4))
    else $error("async path stopped without enable write");
  iso_hold_a: assert property
    (|($past(isoPathRun) & ~isoPathRun)
     |-> $past(isoWr, 2) || $past(isoWr, 3) || $past(isoWr, 4))
    else $error("iso path stopped without enable write");
  clk_gate_a: assert property
    (|(asyncPathRun & ~$past(asyncPathRun))
     || |(isoPathRun & ~$past(isoPathRun)) |-> okAge_r <= 4'h9)
    else $error("path started while underclocked");
  lock_follow_a: assert property
    ($stable(asyncLockIn) [*8] |-> asyncLockSts == asyncLockIn)
    else $error("lock status does not follow input");
  lock_event_a: assert property
    ($changed(asyncLockSts) |-> ##[0:1] asyncLockEvt)
    else $error("lock change without event");
endmodule
bind srcc_ctrl srcc_ctrl_monitor mon
(
  .clk_sys, .rst_n, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbSelI, .wbDatI,
  .wbDatO, .wbAckO, .sysClkAdequate, .asyncClkAdequate, .asyncLockIn,
  .asyncPathRun, .isoPathRun, .asyncLockSts, .asyncLockEvt
);
`default_nettype wire

// ===== dv/srcc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module srcc_ctrl_bench
  import srcc_pkg::*;
;
  localparam logic [15:0] ISO_BITS [4] =
    '{16'h8000, 16'h4000, 16'h0200, 16'h0100};
  logic        clk_sys    = 1'b0;
  logic        rst_n      = 1'b0;
  logic        wbCycI     = 1'b0;
  logic        wbStbI     = 1'b0;
  logic        wbWeI      = 1'b0;
  logic [15:0] wbAdrI     = 16'h0;
  logic [3:0]  wbSelI     = 4'h0;
  logic [31:0] wbDatI     = 32'h0;
  logic [31:0] wbDatO;
  logic        wbAckO;
  logic        sysClkAdequate;
  logic        asyncClkAdequate;
  logic [3:0]  asyncLockIn;
  logic [3:0]  asyncPathRun;
  logic [7:0]  isoPathRun;
  logic [3:0]  asyncLockSts;
  logic        asyncLockEvt;
  logic        sysOkCmd   = 1'b1;
  logic        asyncOkCmd = 1'b1;
  logic [3:0]  lockCmd    = 4'h0;
  logic [31:0] rd;
  int          failures   = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  always #20 clk_sys = ~clk_sys;
  srcc_ctrl dut
  (
    .clk_sys, .rst_n, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbSelI, .wbDatI,
    .wbDatO, .wbAckO, .sysClkAdequate, .asyncClkAdequate, .asyncLockIn,
    .asyncPathRun, .isoPathRun, .asyncLockSts, .asyncLockEvt
  );
  srcc_partner #(.LAG(3)) far
  (
    .clk_sys, .sysOkCmd, .asyncOkCmd, .lockCmd, .sysClkAdequate,
    .asyncClkAdequate, .asyncLockIn
  );
  // ==========================================================================
  // Bus and check tasks.
  task automatic print_verdict();
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic [13:0] idx, input logic we,
                    input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    {wbCycI, wbStbI, wbWeI} <= {2'b11, we};
    wbAdrI <= {idx, 2'b00};
    wbSelI <= 4'h3;
    wbDatI <= {16'h0, d};
    do @(posedge clk_sys); while (wbAckO !== 1'b1);
    q = wbDatO;
    {wbCycI, wbStbI, wbWeI} <= 3'b000;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    wb(idx, 1'b1, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [13:0] idx,
                     input logic [31:0] exp);
    logic [31:0] q;
    wb(idx, 1'b0, 16'h0, q);
    chk(nm, q, exp);
  endtask
  // Sources are taken as cleared; the settling gap is still kept.
  task automatic wrRate(input logic [13:0] idx, input logic [4:0] code);
    repeat (3125) @(posedge clk_sys);
    wr(idx, {code, 11'h000});
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc("sts", IDX_ASYNC_STATUS, 32'h0);
    rdc("ena", IDX_ASYNC_ENABLE, 32'h0);
    rdc("rt1", IDX_ASYNC_RATE1, 32'h0);
    rdc("rt2", IDX_ASYNC_RATE2, 32'h4000);
    rdc("ihi", IDX_ISO1_HIGH, 32'h0);
    rdc("ilo", IDX_ISO1_LOW, 32'h0);
    rdc("ien", IDX_ISO1_ENABLE, 32'h0);
    rdc("nomap", 14'h0ef7, 32'h0);
    wr(IDX_ASYNC_STATUS, 16'h000f);
    rdc("stsro", IDX_ASYNC_STATUS, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_ASYNC_ENABLE, 16'h1 << i);
      rdc("stsbit", IDX_ASYNC_STATUS, 32'h1 << i);
      chk("runbit", asyncPathRun, 32'h1 << i);
    end
    wr(IDX_ASYNC_ENABLE, 16'h0);
    {sysOkCmd, asyncOkCmd} <= 2'b00;
    repeat (12) @(posedge clk_sys);
    wr(IDX_ASYNC_ENABLE, 16'h0003);
    rdc("refuse", IDX_ASYNC_STATUS, 32'h0);
    rdc("askd", IDX_ASYNC_ENABLE, 32'h3);
    {sysOkCmd, asyncOkCmd} <= 2'b11;
    repeat (12) @(posedge clk_sys);
    rdc("late", IDX_ASYNC_STATUS, 32'h3);
    {sysOkCmd, asyncOkCmd} <= 2'b00;
    repeat (12) @(posedge clk_sys);
    chk("keep", asyncPathRun, 32'h3);
    wr(IDX_ASYNC_ENABLE, 16'h0);
    rdc("off", IDX_ASYNC_STATUS, 32'h0);
    chk("offrun", asyncPathRun, 32'h0);
    {sysOkCmd, asyncOkCmd} <= 2'b11;
    wrRate(IDX_ASYNC_RATE1, 5'h03);
    wr(IDX_ASYNC_ENABLE, 16'h0001);
    rdc("rsvd", IDX_ASYNC_STATUS, 32'h0);
    wrRate(IDX_ASYNC_RATE1, RATE_ASYNC_B);
    rdc("code9", IDX_ASYNC_STATUS, 32'h1);
    rdc("rt1b", IDX_ASYNC_RATE1, 32'h4800);
    wr(IDX_ASYNC_ENABLE, 16'h0);
    wrRate(IDX_ISO1_HIGH, RATE_SYS_3);
    wrRate(IDX_ISO1_LOW, RATE_SYS_2);
    rdc("ihi2", IDX_ISO1_HIGH, 32'h1000);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_ISO1_ENABLE, ISO_BITS[i]);
      rdc("isobit", IDX_ISO_STATUS, 32'h8 >> i);
      chk("isorun", isoPathRun, 32'h8 >> i);
    end
    wrRate(IDX_ISO2_HIGH, RATE_ASYNC_B);
    wrRate(IDX_ISO2_LOW, RATE_ASYNC_A);
    wr(IDX_ISO2_ENABLE, 16'hc300);
    rdc("iso2", IDX_ISO_STATUS, 32'hf1);
    wr(IDX_ISO1_ENABLE, 16'h0);
    wrRate(IDX_ISO1_LOW, RATE_ASYNC_A);
    wr(IDX_ISO1_ENABLE, 16'hc300);
    rdc("mixed", IDX_ISO_STATUS, 32'hf0);
    lockCmd <= 4'h6;
    repeat (9) @(posedge clk_sys);
    chk("evt", asyncLockEvt, 32'h1);
    @(posedge clk_sys);
    chk("evtend", asyncLockEvt, 32'h0);
    repeat (6) @(posedge clk_sys);
    chk("lock", asyncLockSts, 32'h6);
    lockCmd <= 4'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("rstrun", isoPathRun, 32'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc("rstrt2", IDX_ASYNC_RATE2, 32'h4000);
    print_verdict();
  end
endmodule
`default_nettype wire
